// ### common/sfar_if.sv
// Serial command link between host and flash device
`timescale 1ns/1ps
`default_nettype none
interface sfar_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe_n;
  logic so_line;
  // Weak pull-up holds the data line high while the device floats it
  assign so_line = so_oe_n ? 1'b1 : so;
  modport dev (input cs_n, input sck, input si, output so, output so_oe_n);
  modport host (output cs_n, output sck, output si, input so_line);
endinterface
`default_nettype wire

// ### common/sfar_pkg.sv
// Shared constants for the serial flash continuous array read link
package sfar_pkg;
  localparam int OPC_W = 8;
  localparam int PAGE_W = 12;
  localparam int BYTE_W = 9;
  localparam int RSVD_W = 3;
  localparam int DUMMY_W = 32;
  localparam int ARR_AW = 21;
  localparam int PAGES = 4096;
  localparam int PAGE_BYTES = 264;
  localparam int ARR_BYTES = PAGES * PAGE_BYTES;
  localparam int BUF_NUM = 2;
  localparam int HDR_W = OPC_W + RSVD_W + PAGE_W + BYTE_W + DUMMY_W;
  localparam int CNT_W = 7;
  localparam int XFER_W = 20;
  localparam logic [OPC_W-1:0] OP_CAR_LEGACY = 8'h68;
  localparam logic [OPC_W-1:0] OP_CAR_SPI = 8'he8;
  localparam logic [RSVD_W-1:0] RSVD_VAL = 3'h0;
  localparam logic [DUMMY_W-1:0] DUMMY_VAL = 32'h0;
  localparam logic [CNT_W-1:0] ADDR_DONE = 7'h1f;
  localparam logic [CNT_W-1:0] HDR_DONE = 7'h3f;
  localparam logic [XFER_W-1:0] HDR_EDGES = 20'h00040;
  localparam logic [BYTE_W-1:0] LAST_BYTE = 9'h107;
  localparam logic [ARR_AW-1:0] PAGE_BYTES_A = 21'h000108;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Serial clock timing made by the host end
  localparam int CLK_NS = 40;
  localparam int SCK_HALF_NS = 160;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS / CLK_NS) < 1 ? 1 : (SCK_HALF_NS / CLK_NS);
  localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);
endpackage

// ### hw/sfar_dev.sv
// Flash device end: command front end and continuous array read
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Command starts at chip select fall, opcode first
// - Bits shift in on clock while selected
// - Everything travels most significant bit first
// - Accept both clock idle levels, modes 0/3
// - Read opcode picks timing category and start
// - Array 4096 pages of 264, two buffers
// - Address is page field plus byte field
// - Opcodes 68H/E8H, address, 32 dummy bits
// - Three reserved, twelve page, nine byte bits
// - One data bit per clock after dummies
// - Host holds select low whole command
// - Internal address counter advances by itself
// - Page end rolls into next page
// - Array end wraps to page zero
// - Select rise ends read, floats output
// - Array read leaves buffers untouched
// - Program self-timed, no erase needed first
// - Programming works on whole pages
module sfar_dev (
  input wire logic clk_sys,
  input wire logic rstn,
  sfar_if.dev link,
  input wire logic buf_we,
  input wire logic buf_sel,
  input wire logic [sfar_pkg::BYTE_W-1:0] buffer_byte_addr,
  input wire logic [7:0] buf_wdata,
  input wire logic prog_start,
  input wire logic prog_buf,
  input wire logic [sfar_pkg::PAGE_W-1:0] prog_page,
  output logic prog_busy
);
  typedef enum logic [3:0] {
    SFAR_IDLE = 4'h1,
    SFAR_CMD = 4'h2,
    SFAR_DATA = 4'h4,
    SFAR_SKIP = 4'h8
  } sfar_dstate_t;

  typedef struct packed {
    sfar_dstate_t state;
    logic cs_q;
    logic sck_q;
    logic [sfar_pkg::CNT_W-1:0] bitcnt;
    logic [31:0] shreg;
    logic skip;
    logic [sfar_pkg::PAGE_W-1:0] page_addr;
    logic [sfar_pkg::BYTE_W-1:0] byte_in_page_addr;
    logic [2:0] bit_idx;
    logic so;
    logic so_oe_n;
    logic busy;
    logic pbuf;
    logic [sfar_pkg::PAGE_W-1:0] ppage;
    logic [sfar_pkg::BYTE_W-1:0] pidx;
  } sfar_dev_t;

  sfar_dev_t r;
  sfar_dev_t next_r;

  logic [7:0] mem [sfar_pkg::ARR_BYTES];
  logic [7:0] bufs [sfar_pkg::BUF_NUM][sfar_pkg::PAGE_BYTES];

  logic [2:0] pins_s;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic rise;
  logic fall;
  logic [31:0] word;
  logic [sfar_pkg::ARR_AW-1:0] rd_addr;
  logic [sfar_pkg::ARR_AW-1:0] wr_addr;
  logic [7:0] rd_byte;

  sfar_sync #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({link.cs_n, link.sck, link.si}),
    .q(pins_s)
  );

  assign cs_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign si_s = pins_s[0];
  // edges found from either idle level
  assign rise = sck_s & ~r.sck_q;
  assign fall = ~sck_s & r.sck_q;
  // new bit enters at the bottom
  assign word = {r.shreg[30:0], si_s};
  // page times page size plus byte
  assign rd_addr = sfar_pkg::ARR_AW'(r.page_addr) * sfar_pkg::PAGE_BYTES_A
                 + sfar_pkg::ARR_AW'(r.byte_in_page_addr);
  assign wr_addr = sfar_pkg::ARR_AW'(r.ppage) * sfar_pkg::PAGE_BYTES_A
                 + sfar_pkg::ARR_AW'(r.pidx);
  // Combinational array read keeps the stream free of fetch gaps
  assign rd_byte = mem[rd_addr];

  always_comb begin
    next_r = r;
    next_r.cs_q = cs_s;
    next_r.sck_q = sck_s;
    case (r.state)
      SFAR_IDLE: begin
        if (!cs_s && r.cs_q) begin
          next_r.state = SFAR_CMD;
          next_r.bitcnt = '0;
        end
      end
      SFAR_CMD: begin
        if (rise) begin
          next_r.shreg = word;
          next_r.bitcnt = r.bitcnt + 1'b1;
          if (r.bitcnt == sfar_pkg::ADDR_DONE) begin
            next_r.page_addr = word[sfar_pkg::BYTE_W +: sfar_pkg::PAGE_W];
            next_r.byte_in_page_addr = word[sfar_pkg::BYTE_W-1:0];
            next_r.bit_idx = '0;
            // only the two read opcodes continue
            if (word[31 -: sfar_pkg::OPC_W] == sfar_pkg::OP_CAR_LEGACY) begin
              next_r.skip = 1'b1;
            end else if (word[31 -: sfar_pkg::OPC_W] == sfar_pkg::OP_CAR_SPI) begin
              next_r.skip = 1'b0;
            end else begin
              next_r.state = SFAR_SKIP;
            end
          end
          if (r.bitcnt == sfar_pkg::HDR_DONE) begin
            next_r.state = SFAR_DATA;
          end
        end
      end
      SFAR_DATA: begin
        if (fall) begin
          // legacy opcode starts one clock later
          if (r.skip) begin
            next_r.skip = 1'b0;
          end else begin
            next_r.so = rd_byte[sfar_pkg::BIT_LAST - r.bit_idx];
            next_r.so_oe_n = 1'b0;
            if (r.bit_idx == sfar_pkg::BIT_LAST) begin
              next_r.bit_idx = '0;
              if (r.byte_in_page_addr == sfar_pkg::LAST_BYTE) begin
                next_r.byte_in_page_addr = '0;
                next_r.page_addr = r.page_addr + 1'b1;
              end else begin
                next_r.byte_in_page_addr = r.byte_in_page_addr + 1'b1;
              end
            end else begin
              next_r.bit_idx = r.bit_idx + 1'b1;
            end
          end
        end
      end
      SFAR_SKIP: begin
        // Unsupported opcodes wait out the select
        next_r.so_oe_n = 1'b1;
      end
      default: begin
        next_r.state = SFAR_IDLE;
      end
    endcase
    if (cs_s) begin
      next_r.state = SFAR_IDLE;
      next_r.so_oe_n = 1'b1;
    end
    if (r.busy) begin
      next_r.pidx = r.pidx + 1'b1;
      if (r.pidx == sfar_pkg::LAST_BYTE) begin
        next_r.busy = 1'b0;
      end
    end else if (prog_start) begin
      next_r.busy = 1'b1;
      next_r.pbuf = prog_buf;
      next_r.ppage = prog_page;
      next_r.pidx = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      // Select history starts low: the synchroniser clears to zero, so a high start would fake a fall
      r <= '{state: SFAR_IDLE, so_oe_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // buffers change only through the user port
  always_ff @(posedge clk_sys) begin
    if (buf_we) begin
      bufs[buf_sel][buffer_byte_addr] <= buf_wdata;
    end
    if (r.busy) begin
      mem[wr_addr] <= bufs[r.pbuf][r.pidx];
    end
  end

  assign link.so = r.so;
  assign link.so_oe_n = r.so_oe_n;
  assign prog_busy = r.busy;
endmodule
`default_nettype wire

// ### hw/sfar_host.sv
// Host end: issues continuous array reads and collects bytes
`timescale 1ns/1ps
`default_nettype none
module sfar_host (
  input wire logic clk_sys,
  input wire logic rstn,
  sfar_if.host link,
  input wire logic start,
  input wire logic use_spi_op,
  input wire logic mode3,
  input wire logic [sfar_pkg::PAGE_W-1:0] page_addr,
  input wire logic [sfar_pkg::BYTE_W-1:0] byte_in_page_addr,
  input wire logic [15:0] nbytes,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  typedef enum logic [3:0] {
    SFAR_H_IDLE = 4'h1,
    SFAR_H_START = 4'h2,
    SFAR_H_RUN = 4'h4,
    SFAR_H_STOP = 4'h8
  } sfar_hstate_t;

  typedef struct packed {
    sfar_hstate_t state;
    logic [3:0] cnt;
    logic cs_n;
    logic sck;
    logic si;
    logic mode3;
    logic [sfar_pkg::XFER_W-1:0] edges;
    logic [sfar_pkg::XFER_W-1:0] first;
    logic [sfar_pkg::XFER_W-1:0] total;
    logic [sfar_pkg::HDR_W-1:0] txsh;
    logic [7:0] rxsh;
    logic [2:0] bitn;
    logic [7:0] rd_data;
    logic rd_valid;
    logic busy;
  } sfar_host_t;

  sfar_host_t r;
  sfar_host_t next_r;
  logic so_s;
  logic [sfar_pkg::XFER_W-1:0] extra;

  sfar_sync #(.W(1)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(link.so_line),
    .q(so_s)
  );

  assign extra = sfar_pkg::XFER_W'(!use_spi_op);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    case (r.state)
      SFAR_H_IDLE: begin
        if (start) begin
          // opcode, address, dummy bits in one word
          next_r.txsh = {use_spi_op ? sfar_pkg::OP_CAR_SPI : sfar_pkg::OP_CAR_LEGACY,
                         sfar_pkg::RSVD_VAL, page_addr, byte_in_page_addr, sfar_pkg::DUMMY_VAL};
          next_r.first = sfar_pkg::HDR_EDGES + extra;
          next_r.total = sfar_pkg::HDR_EDGES + extra + {1'b0, nbytes, 3'h0};
          next_r.mode3 = mode3;
          next_r.sck = mode3;
          // select falls before the first bit
          next_r.cs_n = 1'b0;
          next_r.cnt = '0;
          next_r.edges = '0;
          next_r.bitn = '0;
          next_r.busy = 1'b1;
          next_r.state = SFAR_H_START;
        end
      end
      SFAR_H_START: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == sfar_pkg::HALF_LAST) begin
          next_r.cnt = '0;
          next_r.sck = 1'b0;
          next_r.si = r.txsh[sfar_pkg::HDR_W-1];
          next_r.txsh = r.txsh << 1;
          next_r.state = SFAR_H_RUN;
        end
      end
      SFAR_H_RUN: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == sfar_pkg::HALF_LAST) begin
          next_r.cnt = '0;
          if (!r.sck) begin
            // rising edge lets the device sample
            next_r.sck = 1'b1;
            next_r.edges = r.edges + 1'b1;
          end else begin
            // Sampling late in the high phase covers the pin synchroniser lag
            if (r.edges > r.first) begin
              next_r.rxsh = {r.rxsh[6:0], so_s};
              next_r.bitn = r.bitn + 1'b1;
              if (r.bitn == sfar_pkg::BIT_LAST) begin
                next_r.rd_data = {r.rxsh[6:0], so_s};
                next_r.rd_valid = 1'b1;
              end
            end
            if (r.edges == r.total) begin
              next_r.sck = r.mode3;
              next_r.state = SFAR_H_STOP;
            end else begin
              next_r.sck = 1'b0;
              next_r.si = r.txsh[sfar_pkg::HDR_W-1];
              next_r.txsh = r.txsh << 1;
            end
          end
        end
      end
      SFAR_H_STOP: begin
        next_r.cnt = r.cnt + 1'b1;
        // select stays low until the last bit
        if (r.cnt == sfar_pkg::HALF_LAST) begin
          next_r.cnt = '0;
          next_r.cs_n = 1'b1;
          next_r.busy = 1'b0;
          next_r.state = SFAR_H_IDLE;
        end
      end
      default: begin
        next_r.state = SFAR_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= '{state: SFAR_H_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.cs_n = r.cs_n;
  assign link.sck = r.sck;
  assign link.si = r.si;
  assign busy = r.busy;
  assign rd_data = r.rd_data;
  assign rd_valid = r.rd_valid;
endmodule
`default_nettype wire

// ### hw/sfar_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfar_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfar_sync_t;
  sfar_sync_t r;
  sfar_sync_t next_r;

  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// ### verification/serial_flash_array_read_tb.sv
// Self-checking bench for the serial flash array read link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_array_read_tb;
  logic clk_sys = 1'b0;
  logic rstn, rstn_host, rstn_all;
  logic start, use_spi_op, mode3, busy, rd_valid;
  logic [11:0] page_addr;
  logic [8:0] byte_in_page_addr;
  logic [15:0] nbytes;
  logic [7:0] rd_data;
  logic buf_we, buf_sel, prog_start, prog_buf, prog_busy;
  logic [8:0] buffer_byte_addr;
  logic [7:0] buf_wdata;
  logic [11:0] prog_page;
  logic [11:0] src [4096];
  logic [11:0] bufsrc [2];
  logic sck_q, cs_q;
  logic [31:0] hdr;
  int nr, errors, checks_done, seed;
  always #20 clk_sys = ~clk_sys;
  assign rstn_all = rstn & rstn_host;
  sfar_if link ();
  sfar_dev sfar_dev_i (.clk_sys(clk_sys), .rstn(rstn), .link(link), .buf_we(buf_we), .buf_sel(buf_sel),
    .buffer_byte_addr(buffer_byte_addr), .buf_wdata(buf_wdata), .prog_start(prog_start),
    .prog_buf(prog_buf), .prog_page(prog_page), .prog_busy(prog_busy));
  sfar_host sfar_host_i (.clk_sys(clk_sys), .rstn(rstn_all), .link(link), .start(start),
    .use_spi_op(use_spi_op), .mode3(mode3), .page_addr(page_addr),
    .byte_in_page_addr(byte_in_page_addr), .nbytes(nbytes), .busy(busy), .rd_data(rd_data),
    .rd_valid(rd_valid));
  sfar_props sfar_props_i (.clk_sys(clk_sys), .rstn(rstn_all), .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n));
  // Header bits as seen on the wire, first 32 only
  always @(posedge clk_sys) begin
    sck_q <= link.sck;
    cs_q <= link.cs_n;
    if (link.cs_n) begin
      nr <= 0;
    end else if (link.sck && !sck_q && !cs_q) begin
      nr <= nr + 1;
      if (nr < 32) hdr <= {hdr[30:0], link.si};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [11:0] p, input logic [8:0] b);
    return p[7:0] + {p[11:8], 4'h5} ^ b[7:0] ^ {b[8], 7'h29};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic prog(input logic [11:0] pg, input logic sel, input logic fill);
    for (int b = 0; fill && b < 264; b++) begin
      buf_we <= 1'b1;
      buf_sel <= sel;
      buffer_byte_addr <= 9'(b);
      buf_wdata <= pat(pg, 9'(b));
      @(posedge clk_sys);
    end
    bufsrc[sel] = fill ? pg : bufsrc[sel];
    src[pg] = bufsrc[sel];
    buf_we <= 1'b0;
    prog_start <= 1'b1;
    prog_buf <= sel;
    prog_page <= pg;
    repeat (2) @(posedge clk_sys);
    prog_start <= 1'b0;
    for (int i = 0; i < 400 && prog_busy !== 1'b0; i++) @(posedge clk_sys);
    chk("prog_busy", prog_busy, 1'b0);
    if (prog_busy !== 1'b0) results();
  endtask
  task automatic rd(input logic [11:0] pg, input logic [8:0] by, input int n, input logic spi, input logic m3);
    logic [11:0] p;
    logic [8:0] b;
    int k;
    p = pg;
    b = by;
    k = 0;
    start <= 1'b1;
    use_spi_op <= spi;
    mode3 <= m3;
    page_addr <= pg;
    byte_in_page_addr <= by;
    nbytes <= 16'(n);
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 9000 && (k < n || busy !== 1'b0); i++) begin
      @(posedge clk_sys);
      if (rd_valid === 1'b1) begin
        chk("rd_data", rd_data, pat(src[p], b));
        k++;
        p = (b == 9'h107) ? p + 12'h1 : p;
        b = (b == 9'h107) ? 9'h0 : b + 9'h1;
      end
    end
    chk("bytes", 32'(k), 32'(n));
    chk("header", hdr, {spi ? sfar_pkg::OP_CAR_SPI : sfar_pkg::OP_CAR_LEGACY, 3'h0, pg, by});
    chk("busy", busy, 1'b0);
    // Output floats only three cycles after select rises
    repeat (4) @(posedge clk_sys);
    chk("so_line", link.so_line, 1'b1);
    if (busy !== 1'b0) results();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, start, use_spi_op, mode3, buf_we, buf_sel, prog_start, prog_buf} = 8'h0;
    {page_addr, byte_in_page_addr, nbytes, buffer_byte_addr, buf_wdata, prog_page} = 66'h0;
    {errors, checks_done} = 0;
    rstn_host = 1'b1;
    seed = 14600;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    prog(12'hfff, 1'b0, 1'b1);
    prog(12'h0, 1'b1, 1'b1);
    prog(12'h1, 1'b0, 1'b1);
    // Page end crossing with both opcodes and both idle levels
    for (int i = 0; i < 4; i++) rd(12'h0, 9'h106, 3, i[0], i[1]);
    // Array end wraps to page zero
    rd(12'hfff, 9'h107, 2, 1'b1, 1'b0);
    rd(12'h1, 9'h0, 0, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      rd($random(seed) & 1 ? 12'hfff : 12'h0, 9'($unsigned($random(seed)) % 264),
        1 + $unsigned($random(seed)) % 4, 1'($random(seed)), 1'($random(seed)));
    end
    // Select rises inside the header: command dropped
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (100 + $unsigned($random(seed)) % 300) @(posedge clk_sys);
    rstn_host <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn_host <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("so_oe_n", link.so_oe_n, 1'b1);
    // Buffer still holds page one after the reads
    prog(12'h2, 1'b0, 1'b0);
    rd(12'h2, 9'h0, 2, 1'b1, 1'b0);
    results();
  end
endmodule
`default_nettype wire

// ### verification/sfar_props.sv
// Checker for the serial flash array read link
`timescale 1ns/1ps
`default_nettype none
module sfar_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic sck_d;
  logic cs_d;
  logic [7:0] rises;
  logic [7:0] op;
  // Level step of the clock at select fall is not an edge
  // Counts clear at select fall, so they still stand while the output drains after a rise
  always_ff @(posedge clk_sys) begin
    sck_d <= sck;
    cs_d <= cs_n;
    if (!rstn || (!cs_n && cs_d)) begin
      rises <= 8'h0;
      op <= 8'h0;
    end else if (!cs_n && sck && !sck_d && !cs_d) begin
      rises <= (rises == 8'hff) ? rises : rises + 8'h1;
      op <= (rises < 8'h8) ? {op[6:0], si} : op;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////////
  a_float_idle: assert property (cs_n [*5] |-> so_oe_n)
    else $error("data line driven while deselected");
  a_drive_late: assert property (!so_oe_n |-> rises >= 8'h40)
    else $error("data driven before header end");
  a_opcode_ok: assert property (!so_oe_n |-> op == sfar_pkg::OP_CAR_SPI || op == sfar_pkg::OP_CAR_LEGACY)
    else $error("data driven for unknown opcode");
  a_start_cycle: assert property ($fell(so_oe_n) |-> rises == (op == sfar_pkg::OP_CAR_SPI ? 8'h40 : 8'h41))
    else $error("first data bit on wrong clock");
  a_so_steady: assert property (!so_oe_n && sck && $past(sck) |-> $stable(so))
    else $error("data bit moved while clock high");
  a_si_steady: assert property (!cs_n && sck && $past(sck) |-> $stable(si))
    else $error("input bit moved while clock high");
  a_hdr_whole: assert property ($rose(cs_n) |-> rises >= 8'h40)
    else $error("select released inside header");
  a_idle_clock: assert property (cs_n [*2] |-> $stable(sck))
    else $error("clock moved while deselected");
  c_spi_start: cover property ($fell(so_oe_n) && op == sfar_pkg::OP_CAR_SPI);
  c_late_start: cover property ($fell(so_oe_n) && op == sfar_pkg::OP_CAR_LEGACY);
  c_high_idle: cover property ($fell(cs_n) && sck);
endmodule
`default_nettype wire
